// ===== rtl/fsk_ctrl_pkg.sv
// shared constants, register map and divider helper for the transceiver control
package fsk_ctrl_pkg;

  // ----------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------
  localparam logic [6:0] FRONT_END_MODE_CONTROL_ADDR = 7'h00;
  localparam logic [6:0] FILTER_AND_INDICATOR_CONTROL_ADDR = 7'h01;
  localparam logic [6:0] SYNC_CLOCK_SELECT_ADDR = 7'h06;
  localparam logic [6:0] RATE_SELECT_AND_REF_DIVIDER_ADDR = 7'h07;
  localparam logic [6:0] FREQ_ERROR_CONTROL_ADDR = 7'h15;
  localparam logic [6:0] FREQ_ERROR_RESULT_ADDR = 7'h16;
  localparam logic [6:0] AMP_BYPASS_CONTROL_ADDR = 7'h1F;

  // ----------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------
  localparam logic [7:0] FRONT_END_RESET = 8'h01;
  localparam logic [7:0] FILTER_RESET = 8'h80;
  localparam logic [7:0] SYNC_CLOCK_RESET = 8'h00;
  localparam logic [7:0] RATE_REF_RESET = 8'h01;
  localparam logic [3:0] FREQ_ERROR_CTRL_RESET = 4'h0;
  localparam logic [7:0] FREQ_ERROR_RESULT_RESET = 8'h00;

  // ----------------------------------------------------------
  // field positions and fixed bits
  // ----------------------------------------------------------
  localparam int FE_RX_BYPASS_POS = 7;
  localparam int FE_LEVEL_LSB = 4;
  localparam int FE_SYNC_POS = 3;
  localparam int FE_MODE_LSB = 1;
  localparam int FLT_LEVEL_ON_POS = 3;
  localparam int FLT_LOCK_ON_POS = 2;
  localparam int RATE_LOW_LSB = 6;
  localparam logic [7:0] FE_FIXED_ONES = 8'h01;
  localparam logic [7:0] FLT_FIXED_ONES = 8'h80;

  // ----------------------------------------------------------
  // transceiver modes and estimator modes
  // ----------------------------------------------------------
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_TX = 2'h2;
  localparam logic [1:0] ERR_UP = 2'h1;
  localparam logic [1:0] ERR_DN = 2'h2;
  localparam logic [1:0] ERR_UPDN = 2'h3;
  localparam logic [7:0] SYM_BASE = 8'h08;

  // ----------------------------------------------------------
  // counts
  // ----------------------------------------------------------
  localparam logic [3:0] PHASE_MID = 4'h8;
  localparam logic [4:0] SER_ADDR_LAST = 5'h06;
  localparam logic [4:0] SER_RW_BIT = 5'h07;
  localparam logic [4:0] SER_LAST_BIT = 5'h0F;
  localparam logic [4:0] SER_FRAME_BITS = 5'h10;

  // terminal count of a divider by divisor * 2^(7 - exponent)
  function automatic logic [13:0] div_terminal(input logic [5:0] divisor,
                                               input logic [3:0] exponent);
    logic [5:0] k;
    logic [3:0] shift;
    logic [13:0] full;
    k = (divisor == 6'h00) ? 6'h01 : divisor;
    shift = (exponent > 4'h7) ? 4'h0 : 4'h7 - exponent;
    full = {8'h00, k} << shift;
    return full - 14'h0001;
  endfunction

endpackage

// ===== rtl/ser_port.sv
// three-wire serial register access port
`timescale 1ns/100ps
module ser_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial pins
  input wire logic prog_clk,
  input wire logic prog_enable,
  input wire logic prog_data_i,
  output logic prog_data_o,
  output logic prog_data_oe,
  // register side
  output logic wr_strobe,
  output logic [6:0] reg_addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);

  logic [2:0] sclk_q;
  logic [1:0] en_q;
  logic [1:0] din_q;
  logic [4:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] out_sh_q;
  logic rd_q;
  logic rise;
  logic fall;

  // ----------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------
  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];

  always_ff @(posedge core_clk)
  begin
    sclk_q <= {sclk_q[1:0], prog_clk};
    en_q <= {en_q[0], prog_enable};
    din_q <= {din_q[0], prog_data_i};
  end

  // ----------------------------------------------------------
  // frame: 7 address bits, read flag, 8 data bits
  // ----------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || !en_q[1])
    begin
      bit_cnt_q <= 5'h00;
      shift_q <= 7'h00;
      out_sh_q <= 8'h00;
      rd_q <= 1'b0;
      wr_strobe <= 1'b0;
      prog_data_o <= 1'b0;
      prog_data_oe <= 1'b0;
      if (rst)
      begin
        reg_addr <= 7'h00;
        wr_data <= 8'h00;
      end
    end
    else
    begin
      wr_strobe <= 1'b0;
      if (rise && bit_cnt_q < fsk_ctrl_pkg::SER_FRAME_BITS)
      begin
        shift_q <= {shift_q[5:0], din_q[1]};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == fsk_ctrl_pkg::SER_ADDR_LAST)
          reg_addr <= {shift_q[5:0], din_q[1]};
        if (bit_cnt_q == fsk_ctrl_pkg::SER_RW_BIT)
        begin
          rd_q <= din_q[1];
          out_sh_q <= rd_data;
        end
        if (bit_cnt_q == fsk_ctrl_pkg::SER_LAST_BIT && !rd_q)
        begin
          wr_strobe <= 1'b1;
          wr_data <= {shift_q[6:0], din_q[1]};
        end
      end
      // read data changes on falling edges, host samples on rising
      if (fall && rd_q)
      begin
        prog_data_oe <= (bit_cnt_q < fsk_ctrl_pkg::SER_FRAME_BITS);
        prog_data_o <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

endmodule // ser_port

// ===== rtl/bit_sync.sv
// receive bit synchroniser with 16 phases per bit and data clock
`timescale 1ns/100ps
module bit_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic tick16,
  // received bit, already synchronised
  input wire logic rx_bit,
  // outputs
  output logic data_clk,
  output logic bit_out,
  output logic bit_strobe
);

  logic [3:0] phase_q;
  logic prev_q;
  logic edge_q;
  logic sample_q;
  logic edge_seen;
  logic [3:0] step;

  // ----------------------------------------------------------
  // phase step: an edge early in the bit stalls, late jumps ahead
  // ----------------------------------------------------------
  assign edge_seen = edge_q || (rx_bit != prev_q); // edge on a tick cycle still counts
  assign step = !edge_seen ? 4'h1 :
                (phase_q != 4'h0 && phase_q < fsk_ctrl_pkg::PHASE_MID) ? 4'h0 :
                (phase_q > fsk_ctrl_pkg::PHASE_MID) ? 4'h2 : 4'h1;

  always_ff @(posedge core_clk)
  begin
    if (rst || !enable)
    begin
      phase_q <= 4'h0;
      prev_q <= 1'b0;
      edge_q <= 1'b0;
      sample_q <= 1'b0;
      data_clk <= 1'b0;
      bit_out <= 1'b0;
      bit_strobe <= 1'b0;
    end
    else
    begin
      prev_q <= rx_bit;
      bit_strobe <= 1'b0;
      if (tick16)
      begin
        edge_q <= 1'b0;
        phase_q <= phase_q + step;
        if (phase_q == fsk_ctrl_pkg::PHASE_MID)
          sample_q <= rx_bit;
        // bit changes with the rising data clock
        if (phase_q + step < phase_q || (phase_q + step) == 4'h0)
        begin
          bit_out <= sample_q;
          data_clk <= 1'b1;
          bit_strobe <= 1'b1;
        end
        else if (phase_q + step >= fsk_ctrl_pkg::PHASE_MID)
          data_clk <= 1'b0;
      end
      else if (edge_seen)
        edge_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_bit_on_rise: assert property (
    @(posedge core_clk) disable iff (rst)
    !$rose(data_clk) && enable && $past(enable) |-> $stable(bit_out))
    else $error("received bit changed away from a rising data clock");

endmodule // bit_sync

// ===== rtl/fsk_freq_error_bitsync_tx_ctrl.sv
// transceiver digital control: registers, error estimator, data pin and tx control
`timescale 1ns/100ps
// What this block does
// - up pulse per one, down per zero
// - mode field: off, up, down, up-down
// - measurement length 8, 16, 32, 64 symbols
// - eight-bit result readable, two's complement
// - negative results from down counts or wrap past 127
// - counter wraps beyond signed byte range
// - synchroniser runs only with sync mode set
// - receive data clock derived from bit rate
// - received bit changes on rising clock
// - sync clock is crystal over divider chain
// - divider 1..63, sync setting 0..7
// - one reference divider feeds all clocks
// - alignment within 22 bits worst case
// - level zero switches amplifier off
// - bypass bit keeps level control active
// - divider set follows transmitted bit value
// - data pin input in tx, output rx
// - tx data sampled on rising clock edges in sync mode, every cycle otherwise
module fsk_freq_error_bitsync_tx_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial programming port
  input wire logic prog_clk,
  input wire logic prog_enable,
  input wire logic prog_data_i,
  output logic prog_data_o,
  output logic prog_data_oe,
  // data interface pins
  input wire logic bidir_bit_pin_i,
  output logic bidir_bit_pin_o,
  output logic bidir_bit_pin_oe,
  output logic rx_tx_bit_clock,
  // demodulator
  input wire logic one_update_pulse,
  input wire logic zero_update_pulse,
  input wire logic demod_bit,
  // analog controls
  output logic tx_amp_on,
  output logic [2:0] tx_level_field,
  output logic tx_amp_bypass,
  output logic rx_amp_bypass,
  output logic divider_set_sel,
  output logic signal_level_on,
  output logic lock_detect_on,
  output logic [1:0] prefilter_cutoff_sel
);

  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  logic wr_strobe;
  logic [6:0] reg_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] front_end_q;
  logic [7:0] filter_q;
  logic [7:0] sync_sel_q;
  logic [7:0] rate_ref_q;
  logic [3:0] err_ctrl_q;
  logic [7:0] err_result_q;
  logic amp_bypass_q;
  logic [2:0] up_sync_q;
  logic [2:0] dn_sync_q;
  logic [1:0] demod_sync_q;
  logic [1:0] pin_sync_q;
  logic [13:0] sync_div_q;
  logic [13:0] rate_div_q;
  logic rate_clk_q;
  logic [7:0] err_count_q;
  logic [7:0] err_count_d;
  logic [7:0] sym_count_q;
  logic err_running_q;
  logic err_start;
  logic up_pulse;
  logic dn_pulse;
  logic [1:0] err_mode;
  logic [7:0] sym_target;
  logic sym_strobe;
  logic sync_tick;
  logic rate_tick;
  logic [5:0] shared_ref_divider;
  logic [3:0] sync_clock_exponent;
  logic [3:0] rate_clock_exponent;
  logic [13:0] sync_term;
  logic [13:0] rate_term;
  logic [1:0] transceiver_mode_field;
  logic sync_mode;
  logic rx_mode;
  logic tx_mode;
  logic sync_rx;
  logic tx_clk_rise;
  logic bs_clk;
  logic bs_bit;
  logic bs_strobe;

  // ----------------------------------------------------------
  // serial register port
  // ----------------------------------------------------------
  ser_port u_ser_port (
    .core_clk(core_clk),
    .rst(rst),
    .prog_clk(prog_clk),
    .prog_enable(prog_enable),
    .prog_data_i(prog_data_i),
    .prog_data_o(prog_data_o),
    .prog_data_oe(prog_data_oe),
    .wr_strobe(wr_strobe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // read multiplexer, unmapped addresses read zero
  assign rd_data =
    (reg_addr == fsk_ctrl_pkg::FRONT_END_MODE_CONTROL_ADDR) ? front_end_q :
    (reg_addr == fsk_ctrl_pkg::FILTER_AND_INDICATOR_CONTROL_ADDR) ? filter_q :
    (reg_addr == fsk_ctrl_pkg::SYNC_CLOCK_SELECT_ADDR) ? sync_sel_q :
    (reg_addr == fsk_ctrl_pkg::RATE_SELECT_AND_REF_DIVIDER_ADDR) ? rate_ref_q :
    (reg_addr == fsk_ctrl_pkg::FREQ_ERROR_CONTROL_ADDR) ? {4'h0, err_ctrl_q} :
    (reg_addr == fsk_ctrl_pkg::FREQ_ERROR_RESULT_ADDR) ? err_result_q :
    (reg_addr == fsk_ctrl_pkg::AMP_BYPASS_CONTROL_ADDR) ? {7'h00, amp_bypass_q} :
    8'h00;

  assign err_start = wr_strobe && reg_addr == fsk_ctrl_pkg::FREQ_ERROR_CONTROL_ADDR;

  // ----------------------------------------------------------
  // register file, fixed bits forced on write
  // ----------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      front_end_q <= fsk_ctrl_pkg::FRONT_END_RESET;
      filter_q <= fsk_ctrl_pkg::FILTER_RESET;
      sync_sel_q <= fsk_ctrl_pkg::SYNC_CLOCK_RESET;
      rate_ref_q <= fsk_ctrl_pkg::RATE_REF_RESET;
      err_ctrl_q <= fsk_ctrl_pkg::FREQ_ERROR_CTRL_RESET;
      amp_bypass_q <= 1'b0;
    end
    else if (wr_strobe)
    begin
      if (reg_addr == fsk_ctrl_pkg::FRONT_END_MODE_CONTROL_ADDR)
        front_end_q <= wr_data | fsk_ctrl_pkg::FE_FIXED_ONES;
      if (reg_addr == fsk_ctrl_pkg::FILTER_AND_INDICATOR_CONTROL_ADDR)
        filter_q <= {fsk_ctrl_pkg::FLT_FIXED_ONES[7:4], wr_data[3:0]};
      if (reg_addr == fsk_ctrl_pkg::SYNC_CLOCK_SELECT_ADDR)
        sync_sel_q <= {4'h0, wr_data[3:0]};
      if (reg_addr == fsk_ctrl_pkg::RATE_SELECT_AND_REF_DIVIDER_ADDR)
        rate_ref_q <= wr_data;
      if (err_start)
        err_ctrl_q <= wr_data[3:0];
      if (reg_addr == fsk_ctrl_pkg::AMP_BYPASS_CONTROL_ADDR)
        amp_bypass_q <= wr_data[0];
    end
  end

  // ----------------------------------------------------------
  // field decode
  // ----------------------------------------------------------
  assign transceiver_mode_field = front_end_q[fsk_ctrl_pkg::FE_MODE_LSB +: 2];
  assign sync_mode = front_end_q[fsk_ctrl_pkg::FE_SYNC_POS];
  assign rx_mode = transceiver_mode_field == fsk_ctrl_pkg::MODE_RX;
  assign tx_mode = transceiver_mode_field == fsk_ctrl_pkg::MODE_TX;
  assign sync_rx = sync_mode && rx_mode;
  assign err_mode = err_ctrl_q[1:0];
  assign sym_target = fsk_ctrl_pkg::SYM_BASE << err_ctrl_q[3:2];

  // ----------------------------------------------------------
  // shared reference divider and clock dividers
  // ----------------------------------------------------------
  assign shared_ref_divider = rate_ref_q[5:0];
  assign sync_clock_exponent = {1'b0, sync_sel_q[3:1]};
  assign rate_clock_exponent = {1'b0, sync_sel_q[0], rate_ref_q[7:6]};
  // sync clock runs at 16 ticks per bit
  assign sync_term = fsk_ctrl_pkg::div_terminal(shared_ref_divider,
                                               sync_clock_exponent);
  // rate clock toggles twice per bit, so half the bit period
  assign rate_term = fsk_ctrl_pkg::div_terminal(shared_ref_divider,
                                               rate_clock_exponent + 4'h1);
  assign sync_tick = sync_div_q >= sync_term;
  assign rate_tick = rate_div_q >= rate_term;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync_div_q <= 14'h0000;
      rate_div_q <= 14'h0000;
      rate_clk_q <= 1'b0;
    end
    else
    begin
      sync_div_q <= sync_tick ? 14'h0000 : sync_div_q + 14'h0001;
      rate_div_q <= rate_tick ? 14'h0000 : rate_div_q + 14'h0001;
      if (rate_tick)
        rate_clk_q <= ~rate_clk_q;
    end
  end

  assign tx_clk_rise = rate_tick && !rate_clk_q;

  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    up_sync_q <= {up_sync_q[1:0], one_update_pulse};
    dn_sync_q <= {dn_sync_q[1:0], zero_update_pulse};
    demod_sync_q <= {demod_sync_q[0], demod_bit};
    pin_sync_q <= {pin_sync_q[0], bidir_bit_pin_i};
  end

  // rising edges of the demodulator update pulses
  assign up_pulse = up_sync_q[1] && !up_sync_q[2];
  assign dn_pulse = dn_sync_q[1] && !dn_sync_q[2];

  // ----------------------------------------------------------
  // bit synchroniser
  // ----------------------------------------------------------
  bit_sync u_bit_sync (
    .core_clk(core_clk),
    .rst(rst),
    .enable(sync_rx),
    .tick16(sync_tick),
    .rx_bit(demod_sync_q[1]),
    .data_clk(bs_clk),
    .bit_out(bs_bit),
    .bit_strobe(bs_strobe)
  );

  // ----------------------------------------------------------
  // frequency error estimator
  // ----------------------------------------------------------
  // symbols counted on the recovered bit, else on the rate clock
  assign sym_strobe = sync_rx ? bs_strobe : tx_clk_rise;

  // signed count, wraps past -128 and 127
  assign err_count_d =
    (err_mode == fsk_ctrl_pkg::ERR_UP && up_pulse) ? err_count_q + 8'h01 :
    (err_mode == fsk_ctrl_pkg::ERR_DN && dn_pulse) ? err_count_q - 8'h01 :
    (err_mode == fsk_ctrl_pkg::ERR_UPDN && up_pulse && !dn_pulse) ?
      err_count_q + 8'h01 :
    (err_mode == fsk_ctrl_pkg::ERR_UPDN && dn_pulse && !up_pulse) ?
      err_count_q - 8'h01 : err_count_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      err_count_q <= 8'h00;
      sym_count_q <= 8'h00;
      err_running_q <= 1'b0;
      err_result_q <= fsk_ctrl_pkg::FREQ_ERROR_RESULT_RESET;
    end
    else if (err_start)
    begin
      err_count_q <= 8'h00;
      sym_count_q <= 8'h00;
      err_running_q <= wr_data[1:0] != 2'h0;
    end
    else if (err_running_q)
    begin
      err_count_q <= err_count_d;
      if (sym_strobe)
      begin
        sym_count_q <= sym_count_q + 8'h01;
        if (sym_count_q + 8'h01 == sym_target)
        begin
          err_result_q <= err_count_d;
          err_running_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // data pin, data clock and transmit control
  // ----------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bidir_bit_pin_o <= 1'b0;
      bidir_bit_pin_oe <= 1'b0;
      rx_tx_bit_clock <= 1'b0;
      divider_set_sel <= 1'b0;
    end
    else
    begin
      bidir_bit_pin_oe <= rx_mode;
      bidir_bit_pin_o <= sync_rx ? bs_bit : demod_sync_q[1];
      rx_tx_bit_clock <= sync_rx ? bs_clk :
                         (sync_mode && tx_mode) ? rate_clk_q : 1'b0;
      if (tx_mode && (!sync_mode || tx_clk_rise))
        divider_set_sel <= pin_sync_q[1];
    end
  end

  // analog control outputs
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_amp_on <= 1'b0;
      tx_level_field <= 3'h0;
      tx_amp_bypass <= 1'b0;
      rx_amp_bypass <= 1'b0;
      signal_level_on <= 1'b0;
      lock_detect_on <= 1'b0;
      prefilter_cutoff_sel <= 2'h0;
    end
    else
    begin
      tx_level_field <= front_end_q[fsk_ctrl_pkg::FE_LEVEL_LSB +: 3];
      tx_amp_on <= tx_mode && front_end_q[fsk_ctrl_pkg::FE_LEVEL_LSB +: 3] != 3'h0;
      tx_amp_bypass <= amp_bypass_q;
      rx_amp_bypass <= front_end_q[fsk_ctrl_pkg::FE_RX_BYPASS_POS];
      signal_level_on <= filter_q[fsk_ctrl_pkg::FLT_LEVEL_ON_POS];
      lock_detect_on <= filter_q[fsk_ctrl_pkg::FLT_LOCK_ON_POS];
      prefilter_cutoff_sel <= filter_q[1:0];
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_pin_direction: assert property (
    @(posedge core_clk) disable iff (rst)
    ##1 bidir_bit_pin_oe == $past(rx_mode))
    else $error("data pin direction does not follow mode");

  a_amp_level_off: assert property (
    @(posedge core_clk) disable iff (rst)
    front_end_q[6:4] == 3'h0 |=> !tx_amp_on)
    else $error("amplifier on with level zero");

  a_result_held: assert property (
    @(posedge core_clk) disable iff (rst)
    !err_running_q && !err_start |=> $stable(err_result_q))
    else $error("estimator result changed while idle");

  a_up_only_count: assert property (
    @(posedge core_clk) disable iff (rst)
    err_running_q && !err_start && err_mode == fsk_ctrl_pkg::ERR_UP
    |=> err_count_q == $past(err_count_q) + {7'h00, $past(up_pulse)})
    else $error("up-only mode counted wrongly");

  a_updn_cancel: assert property (
    @(posedge core_clk) disable iff (rst)
    err_running_q && !err_start && err_mode == fsk_ctrl_pkg::ERR_UPDN
    && up_pulse && dn_pulse |=> $stable(err_count_q))
    else $error("simultaneous pulses did not cancel");

  a_sync_clock_off: assert property (
    @(posedge core_clk) disable iff (rst)
    !sync_mode ##1 !sync_mode |-> !rx_tx_bit_clock)
    else $error("data clock running outside sync mode");

  a_tx_sample_rise: assert property (
    @(posedge core_clk) disable iff (rst)
    $changed(divider_set_sel) && $past(sync_mode) && $past(tx_mode)
    |-> $past(tx_clk_rise))
    else $error("tx bit taken away from a rising clock");

  a_sym_length: assert property (
    @(posedge core_clk) disable iff (rst)
    err_running_q |-> sym_count_q < sym_target)
    else $error("measurement ran past its symbol count");

endmodule // fsk_freq_error_bitsync_tx_ctrl

// ===== sim/fsk_host.sv
// host model: serial register frames and received-bit sampling
`timescale 1ns/100ps
module fsk_host (
  // clock
  input wire logic core_clk,
  // serial port
  output logic prog_clk,
  output logic prog_enable,
  output logic prog_drv,
  input wire logic prog_wire,
  // data pins
  input wire logic dclk,
  input wire logic bit_wire,
  output logic rx_sample
);
  // idle serial lines
  initial
  begin
    prog_clk = 1'b0;
    prog_enable = 1'b0;
    prog_drv = 1'b0;
  end

  // received bit taken on the falling data clock
  always @(negedge dclk) rx_sample <= bit_wire;

  // one 16-bit frame, msb first; read bits taken as the clock rises
  task automatic frame(input logic [15:0] f, output logic [7:0] rd);
    prog_enable = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      prog_drv = f[i];
      repeat (6) @(posedge core_clk);
      #1 prog_clk = 1'b1;
      if (i < 8) rd[i] = prog_wire;
      repeat (6) @(posedge core_clk);
      #1 prog_clk = 1'b0;
    end
    repeat (6) @(posedge core_clk);
    #1 prog_enable = 1'b0;
    prog_drv = ~prog_drv;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
endmodule // fsk_host

// ===== sim/fsk_freq_error_bitsync_tx_ctrl_tb.sv
// self-checking testbench for the transceiver control block
`timescale 1ns/100ps
module fsk_freq_error_bitsync_tx_ctrl_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b0, up = 1'b0, dn = 1'b0, dbit = 1'b0;
  logic pc, pe, pd, pdo, pdoe, bo, boe, dclk, amp, byp, dsel, rs;
  logic [2:0] lvl;
  logic lnab, sl, ld;
  logic [1:0] pf;
  logic [7:0] rd;
  wire pw = pdoe ? pdo : pd;
  wire bw = boe ? bo : pin;
  int failures = 0;
  int cmp_count = 0;
  int n = 0;
  logic [6:0] ra [8] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h15, 7'h16, 7'h10, 7'h1F};
  logic [7:0] rv [8] = '{8'h01, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] fe [4] = '{8'h00, 8'h05, 8'hFD, 8'h02};

  // clock and data clock edge counter
  always #4 core_clk = ~core_clk;
  always @(posedge dclk) n++;

  fsk_freq_error_bitsync_tx_ctrl DUT (
    .core_clk(core_clk), .rst(rst), .prog_clk(pc), .prog_enable(pe), .prog_data_i(pw),
    .prog_data_o(pdo), .prog_data_oe(pdoe), .bidir_bit_pin_i(bw), .bidir_bit_pin_o(bo),
    .bidir_bit_pin_oe(boe), .rx_tx_bit_clock(dclk), .one_update_pulse(up),
    .zero_update_pulse(dn), .demod_bit(dbit), .tx_amp_on(amp), .tx_level_field(lvl),
    .tx_amp_bypass(byp), .rx_amp_bypass(lnab), .divider_set_sel(dsel), .signal_level_on(sl),
    .lock_detect_on(ld), .prefilter_cutoff_sel(pf));
  fsk_host u_host (.core_clk(core_clk), .prog_clk(pc), .prog_enable(pe), .prog_drv(pd),
    .prog_wire(pw), .dclk(dclk), .bit_wire(bw), .rx_sample(rs));

  // wait k edges, then step just past the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // compare and count
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // register write and read-compare over the serial port
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame({a, 1'b0, d}, rd);
    cyc(4);
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    u_host.frame({a, 1'b1, 8'h00}, rd);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  // demodulator pulses, ups first
  task automatic pulse(input int nu, input int nd);
    for (int i = 0; i < nu + nd; i++)
    begin
      if (i < nu) up = 1'b1;
      else dn = 1'b1;
      cyc(3);
      up = 1'b0;
      dn = 1'b0;
      cyc(3);
    end
  endtask
  // counts, verdict and end of run
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #400000;
    failures++;
    print_verdict();
  end

  // test sequence
  initial
  begin
    cyc(12);
    rst = 1'b0;
    cyc(4);
    for (int i = 0; i < 8; i++) rc(ra[i], rv[i]);
    wr(7'h16, 8'h5A);
    rc(7'h16, 8'h00);
    wr(7'h07, 8'h3F);
    rc(7'h07, 8'h3F);
    wr(7'h07, 8'h01);
    wr(7'h01, 8'h0F);
    chk("filter pins", 8'h0F, {4'h0, sl, ld, pf});
    $display("end of register test");
    for (int m = 1; m < 4; m++)
    begin
      wr(7'h15, 8'(m));
      pulse(5, 3);
      cyc(1500);
      pulse(2, 2);
      rc(7'h16, fe[m]);
    end
    wr(7'h15, 8'h0D);
    cyc(1100);
    pulse(130, 0);
    cyc(7500);
    rc(7'h16, 8'h82);
    $display("end of estimator test");
    wr(7'h00, 8'h55);
    chk("tx pins", 8'h1A, {3'h0, amp, lvl, boe});
    wr(7'h1F, 8'h01);
    chk("bypass", 8'h0D, {4'h0, byp, lvl});
    wr(7'h00, 8'h05);
    chk("amp off", 8'h00, {7'h00, amp});
    pin = 1'b1;
    cyc(6);
    chk("div set", 8'h01, {7'h00, dsel});
    pin = 1'b0;
    cyc(6);
    chk("div set", 8'h00, {7'h00, dsel});
    wr(7'h00, 8'h0D);
    @(negedge dclk);
    #1 pin = 1'b1;
    cyc(6);
    chk("sync div hold", 8'h00, {7'h00, dsel});
    @(posedge dclk);
    cyc(1);
    chk("sync div set", 8'h01, {7'h00, dsel});
    $display("end of transmit test");
    wr(7'h00, 8'h83);
    dbit = 1'b1;
    cyc(6);
    chk("rx pin", 8'h07, {5'h00, lnab, boe, bo});
    chk("clock idle", 8'h00, {7'h00, dclk});
    wr(7'h06, 8'h0E);
    wr(7'h00, 8'h0B);
    cyc(480);
    n = 0;
    cyc(480);
    chk("clock edges", 8'h1E, 8'(n));
    chk("rx bit", 8'h01, {7'h00, rs});
    dbit = 1'b0;
    cyc(480);
    chk("rx bit", 8'h00, {7'h00, rs});
    $display("end of receive test");
    print_verdict();
  end
endmodule // fsk_freq_error_bitsync_tx_ctrl_tb
